// file: ddsq_sequencer.sv
// Purpose: Row/column strobe sequencer for the display-memory DRAM port
// Assumes: clk_sys is the memory clock; sequencer clock is SEQ_DIV clk_sys cycles
// Notes: Commands pass a 4-word FIFO; same-row same-kind commands burst in page mode
`timescale 1ns/1ns
`include "ddsq_defs.svh"

// Contract
// RL1: Row strobe to column strobe at least 2.5
// RL2: Row address held 1.0 after row fall
// RL3: Column address held 1.0 after column fall
// RL4: Row precharge high at least 3.0
// RL5: Column strobe high 0.5 between accesses
// RL6: Row low at least 4.0, page max 32us
// RL7: Column low at least 1.5, max 32us
// RL8: Column high 0.5 before row falls
// RL9: Column rise at least 4.0 after row fall
// RL10: Memory returns read data within stated delays
// RL11: Write strobe high 0.5 after column rise
// RL12: Write strobe high 1.0 after row rise
// RL13: Row low 1.5 after output enable falls
// RL14: Write low 0.5 around column fall
// RL15: Write strobe low pulse at least 1.0
// RL16: Write data held 1.0 after column fall
// RL17: Column rise 1.0 after write strobe falls
// RL18: Refresh column low 1.0 before row falls
// RL19: Refresh row low 4.0, high 3.0, period 7.0
// RL20: Refresh column low 1.5 after row falls
// RL21: Refresh burst is three or four row pulses
// RL22: Refresh column high 2.0, row-to-column 1.0
// RL23: One operation at a time, idle high after reset
// RL24: Minimum intervals rounded up in half periods
module ddsq_sequencer #(
  parameter logic [7:0] SEQ_DIV = 8'h01,
  parameter int RAS_MAX_CYC = `DDSQ_RAS_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [`DDSQ_ADDR_W-1:0] cmd_row,
  input wire logic [`DDSQ_ADDR_W-1:0] cmd_col,
  input wire logic [`DDSQ_DATA_W-1:0] cmd_wdata,
  input wire logic cmd_write,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output ddsq_pkg::ddsq_data_t rd_data,
  output logic rd_valid,
  input wire logic ref_req,
  input wire logic ref_four,
  output logic ref_ack,
  output logic busy,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_strobe_n,
  output logic output_enable_n,
  output ddsq_pkg::ddsq_addr_t mem_addr,
  output ddsq_pkg::ddsq_data_t mem_data_o,
  output logic mem_data_oe,
  input wire logic [`DDSQ_DATA_W-1:0] mem_data_i
);
  import ddsq_pkg::*;

  // ----------------------------------------------------------------
  // Derived counts
  // ----------------------------------------------------------------
  localparam logic [11:0] RAS_LIMIT = 12'(RAS_MAX_CYC - `DDSQ_PAGE_MARGIN);
  localparam int SD = int'(SEQ_DIV);
  localparam logic [7:0] RP_W = 8'(`DDSQ_RP_CYC - 1); // RL24
  localparam logic [7:0] RCD_W = 8'(`DDSQ_CYC(`DDSQ_T_RCD_HALF) - 2);
  localparam logic [7:0] CAS_W = 8'(`DDSQ_CAS_CYC - 1);
  localparam logic [7:0] CP_W = 8'(`DDSQ_CP_CYC - 1);
  localparam logic [7:0] RCPN_W = 8'(`DDSQ_CYC(`DDSQ_T_CPN_HALF) * SD - 1);
  localparam logic [7:0] RCSR_W = 8'(`DDSQ_CYC(`DDSQ_T_CSR_HALF) * SD - 1);
  localparam logic [7:0] RRAS_W = 8'(`DDSQ_CYC(`DDSQ_T_RRAS_HALF) * SD - 1);
  localparam logic [7:0] RRP_W = 8'(`DDSQ_CYC(`DDSQ_T_RRP_HALF) * SD - 1);

  typedef struct packed {
    ddsq_state_e state;
    logic [7:0] wait_cnt;
    logic [11:0] ras_cnt;
    logic [2:0] ref_left;
    logic is_wr;
    ddsq_addr_t row;
    ddsq_addr_t ma;
    ddsq_data_t md_o;
    logic md_oe;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic ack;
    logic bsy;
    ddsq_data_t md_s1;
    ddsq_data_t md_s2;
    logic [1:0] cap;
    ddsq_data_t rdat;
    logic rvld;
  } ddsq_seq_s;

  ddsq_seq_s s_ff;
  ddsq_seq_s nxt_s;
  logic [`DDSQ_CMD_W-1:0] fifo_in;
  logic [`DDSQ_CMD_W-1:0] head;
  logic head_vld;
  logic pop;
  logic h_wr;
  ddsq_addr_t h_row;
  ddsq_addr_t h_col;
  ddsq_data_t h_dat;
  logic page_ok;

  // ----------------------------------------------------------------
  // Command FIFO
  // ----------------------------------------------------------------
  assign fifo_in = {cmd_write, cmd_row, cmd_col, cmd_wdata};

  ddsq_fifo #(
    .WIDTH(`DDSQ_CMD_W),
    .DEPTH(`DDSQ_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_data(fifo_in),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .out_data(head),
    .out_valid(head_vld),
    .out_ready(pop)
  );

  assign h_wr = head[`DDSQ_CMD_WR_BIT];
  assign h_row = head[`DDSQ_CMD_ROW_LSB +: `DDSQ_ADDR_W];
  assign h_col = head[`DDSQ_CMD_COL_LSB +: `DDSQ_ADDR_W];
  assign h_dat = head[`DDSQ_CMD_DAT_LSB +: `DDSQ_DATA_W];

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign row_strobe_n = s_ff.ras_n;
  assign column_strobe_n = s_ff.cas_n;
  assign write_strobe_n = s_ff.we_n;
  assign output_enable_n = s_ff.oe_n;
  assign mem_addr = s_ff.ma;
  assign mem_data_o = s_ff.md_o;
  assign mem_data_oe = s_ff.md_oe;
  assign rd_data = s_ff.rdat;
  assign rd_valid = s_ff.rvld;
  assign ref_ack = s_ff.ack;
  assign busy = s_ff.bsy;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    pop = 1'b0;
    nxt_s.ack = 1'b0;
    nxt_s.rvld = 1'b0;
    nxt_s.md_s1 = mem_data_i;
    nxt_s.md_s2 = s_ff.md_s1;
    nxt_s.cap = {s_ff.cap[0], 1'b0};
    if (s_ff.cap[1]) begin
      nxt_s.rdat = s_ff.md_s2;
      nxt_s.rvld = 1'b1;
    end
    if (s_ff.wait_cnt != 8'h00) begin
      nxt_s.wait_cnt = s_ff.wait_cnt - 8'h01;
    end
    if (!s_ff.ras_n && s_ff.ras_cnt != 12'hFFF) begin
      nxt_s.ras_cnt = s_ff.ras_cnt + 12'h001;
    end
    page_ok = head_vld && (h_row == s_ff.row) && (h_wr == s_ff.is_wr) &&
              (s_ff.ras_cnt < RAS_LIMIT);
    nxt_s.bsy = (s_ff.state != ST_IDLE);
    unique case (s_ff.state)
      ST_IDLE: begin
        if (ref_req) begin
          nxt_s.state = ST_REF_PRE; // RL23
          nxt_s.ack = 1'b1;
          nxt_s.bsy = 1'b1;
          nxt_s.ref_left = ref_four ? 3'(`DDSQ_REF_PULSES_HI)
                                    : 3'(`DDSQ_REF_PULSES_LO); // RL21
          nxt_s.wait_cnt = RCPN_W; // RL22
        end else if (head_vld) begin
          nxt_s.state = ST_RCD; // RL8
          nxt_s.bsy = 1'b1;
          nxt_s.ras_n = 1'b0;
          nxt_s.ras_cnt = 12'h000;
          nxt_s.row = h_row;
          nxt_s.is_wr = h_wr;
          nxt_s.ma = h_row;
          nxt_s.wait_cnt = RCD_W;
        end
      end
      ST_RCD: begin
        if (s_ff.wait_cnt == 8'h00) begin
          nxt_s.state = ST_COL_SET; // RL2
          nxt_s.ma = h_col;
          nxt_s.md_o = h_dat;
          nxt_s.md_oe = s_ff.is_wr;
          nxt_s.we_n = !s_ff.is_wr; // RL14
          nxt_s.oe_n = s_ff.is_wr; // RL13
        end
      end
      ST_COL_SET, ST_CAS_HI: begin
        if (s_ff.wait_cnt == 8'h00) begin
          nxt_s.state = ST_CAS_LO; // RL1
          nxt_s.cas_n = 1'b0;
          pop = 1'b1;
          nxt_s.wait_cnt = CAS_W; // RL7 RL17
        end
      end
      ST_CAS_LO: begin
        // Column, data and write strobe stay put for the whole low pulse
        if (s_ff.wait_cnt == 8'h00) begin
          nxt_s.cas_n = 1'b1; // RL9
          nxt_s.we_n = 1'b1; // RL15
          nxt_s.md_oe = 1'b0; // RL16
          if (!s_ff.is_wr) begin
            nxt_s.cap = 2'b01;
          end
          if (page_ok) begin
            nxt_s.state = ST_CAS_HI; // RL5
            nxt_s.ma = h_col; // RL3
            nxt_s.md_o = h_dat;
            nxt_s.md_oe = s_ff.is_wr;
            nxt_s.we_n = !s_ff.is_wr; // RL11
            nxt_s.wait_cnt = CP_W;
          end else begin
            nxt_s.state = ST_END; // RL6
            nxt_s.ras_n = 1'b1;
            nxt_s.oe_n = 1'b1;
            nxt_s.wait_cnt = RP_W; // RL4
          end
        end
      end
      ST_END: begin
        if (s_ff.wait_cnt == 8'h00) begin
          nxt_s.state = ST_IDLE; // RL12
          nxt_s.bsy = 1'b0;
        end
      end
      ST_REF_PRE: begin
        if (s_ff.wait_cnt == 8'h00) begin
          nxt_s.state = ST_REF_CAS;
          nxt_s.cas_n = 1'b0;
          nxt_s.wait_cnt = RCSR_W; // RL18
        end
      end
      ST_REF_CAS, ST_REF_HI: begin
        if (s_ff.wait_cnt == 8'h00) begin
          nxt_s.state = ST_REF_LO;
          nxt_s.ras_n = 1'b0;
          nxt_s.wait_cnt = RRAS_W; // RL19
        end
      end
      ST_REF_LO: begin
        // Column strobe stays low across the whole burst
        if (s_ff.wait_cnt == 8'h00) begin
          nxt_s.ras_n = 1'b1; // RL20
          nxt_s.ref_left = s_ff.ref_left - 3'h1;
          nxt_s.wait_cnt = RRP_W; // RL19
          if (s_ff.ref_left == 3'h1) begin
            nxt_s.state = ST_REF_END; // RL21
            nxt_s.cas_n = 1'b1;
          end else begin
            nxt_s.state = ST_REF_HI;
          end
        end
      end
      ST_REF_END: begin
        if (s_ff.wait_cnt == 8'h00) begin
          nxt_s.state = ST_IDLE; // RL22
          nxt_s.bsy = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.state <= ST_IDLE; // RL23
      s_ff.ras_n <= 1'b1;
      s_ff.cas_n <= 1'b1;
      s_ff.we_n <= 1'b1;
      s_ff.oe_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Derived counts round half periods up (RL24 is met by DDSQ_CYC)
endmodule : ddsq_sequencer

// file: ddsq_defs.svh
// Purpose: Timing and field constants for the display DRAM sequencer
// Assumes: clk_sys is the memory clock, 8 ns period
// Notes: Fractional limits are given in half periods and rounded up
`ifndef DDSQ_DEFS_SVH
`define DDSQ_DEFS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define DDSQ_CLK_NS 8

// ----------------------------------------------------------------
// Access timing, in half memory-clock periods
// ----------------------------------------------------------------
`define DDSQ_T_RCD_HALF 5
`define DDSQ_T_RAH_HALF 2
`define DDSQ_T_CAH_HALF 2
`define DDSQ_T_RP_HALF 6
`define DDSQ_T_CP_HALF 1
`define DDSQ_T_CAS_HALF 3
`define DDSQ_T_RSH_HALF 8
`define DDSQ_T_WCS_HALF 1
`define DDSQ_T_RAS_MAX_US 32

// Half periods to whole cycles, rounded up, zero only for zero
`define DDSQ_CYC(h) (((h) + 1) / 2)
`define DDSQ_RP_CYC `DDSQ_CYC(`DDSQ_T_RP_HALF)
`define DDSQ_CAS_CYC `DDSQ_CYC(`DDSQ_T_CAS_HALF)
`define DDSQ_CP_CYC `DDSQ_CYC(`DDSQ_T_CP_HALF)
`define DDSQ_RAS_MAX_CYC ((`DDSQ_T_RAS_MAX_US * 1000) / `DDSQ_CLK_NS)
`define DDSQ_PAGE_MARGIN 16

// ----------------------------------------------------------------
// Refresh timing, in half sequencer-clock periods
// ----------------------------------------------------------------
`define DDSQ_T_CSR_HALF 2
`define DDSQ_T_RRAS_HALF 8
`define DDSQ_T_RRP_HALF 6
`define DDSQ_T_CHR_HALF 3
`define DDSQ_T_CPN_HALF 4
`define DDSQ_T_RPC_HALF 2
`define DDSQ_REF_PULSES_LO 3
`define DDSQ_REF_PULSES_HI 4

// ----------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------
`define DDSQ_ADDR_W 9
`define DDSQ_DATA_W 16
`define DDSQ_CMD_W 35
`define DDSQ_CMD_WR_BIT 34
`define DDSQ_CMD_ROW_LSB 25
`define DDSQ_CMD_COL_LSB 16
`define DDSQ_CMD_DAT_LSB 0
`define DDSQ_FIFO_DEPTH 4

`endif

// file: ddsq_pkg.sv
// Purpose: Types for the display DRAM sequencer
// Assumes: ddsq_defs.svh supplies the numbers
// Notes: None
`include "ddsq_defs.svh"

package ddsq_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RCD,
    ST_COL_SET,
    ST_CAS_LO,
    ST_CAS_HI,
    ST_END,
    ST_REF_PRE,
    ST_REF_CAS,
    ST_REF_LO,
    ST_REF_HI,
    ST_REF_END
  } ddsq_state_e;

  typedef logic [`DDSQ_ADDR_W-1:0] ddsq_addr_t;
  typedef logic [`DDSQ_DATA_W-1:0] ddsq_data_t;

endpackage : ddsq_pkg

// file: ddsq_fifo.sv
// Purpose: Command FIFO in front of the DRAM sequencer
// Assumes: Single clock, synchronous active-high reset
// Notes: Ready and valid are registered
`timescale 1ns/1ns

module ddsq_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] cnt;
    logic in_rdy;
    logic out_vld;
  } ddsq_fifo_s;

  ddsq_fifo_s s_ff;
  ddsq_fifo_s nxt_s;
  logic push;
  logic pop;

  assign in_ready = s_ff.in_rdy;
  assign out_valid = s_ff.out_vld;
  assign out_data = s_ff.mem[s_ff.rptr];

  // ----------------------------------------------------------------
  // Pointer and count update
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    push = in_valid && s_ff.in_rdy;
    pop = out_ready && s_ff.out_vld;
    if (push) begin
      nxt_s.mem[s_ff.wptr] = in_data;
      nxt_s.wptr = (s_ff.wptr == PW'(DEPTH - 1)) ? '0 : s_ff.wptr + 1'b1;
    end
    if (pop) begin
      nxt_s.rptr = (s_ff.rptr == PW'(DEPTH - 1)) ? '0 : s_ff.rptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
    nxt_s.in_rdy = (nxt_s.cnt != CW'(DEPTH));
    nxt_s.out_vld = (nxt_s.cnt != '0);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.in_rdy <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule : ddsq_fifo

// file: ddsq_sequencer_properties.sv
// Purpose: Strobe timing checks on the display DRAM port
// Assumes: Sequencer clock equals clk_sys
// Notes: Fractional minima are checked as whole cycles, rounded up
`timescale 1ns/1ns

module ddsq_checker #(
  parameter int RAS_MAX_CYC = 4000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic busy,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire ddsq_pkg::ddsq_addr_t mem_addr,
  input wire ddsq_pkg::ddsq_data_t mem_data_o,
  input wire logic mem_data_oe
);
  import ddsq_pkg::*;
  int unsigned low_cnt_ff;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || row_strobe_n) begin
      low_cnt_ff <= 0;
    end else begin
      low_cnt_ff <= low_cnt_ff + 1;
    end
  end
  AST_RCD: assert property (
    $fell(row_strobe_n) && column_strobe_n |-> column_strobe_n [*3])
    else $error("row to column delay short");
  AST_ROW_HOLD: assert property (
    $fell(row_strobe_n) && column_strobe_n |=> $stable(mem_addr))
    else $error("row address hold short");
  AST_WE_CAS_HI: assert property (
    $fell(write_strobe_n) |=> !$rose(column_strobe_n))
    else $error("column released early after write strobe");
  AST_COL_HOLD: assert property (
    $fell(column_strobe_n) && !row_strobe_n |=> $stable(mem_addr))
    else $error("column address hold short");
  AST_PRECHARGE: assert property (
    $rose(row_strobe_n) |-> row_strobe_n [*3])
    else $error("row precharge short");
  AST_RAS_MIN: assert property (
    $fell(row_strobe_n) |-> !row_strobe_n [*4])
    else $error("row low pulse short");
  AST_RAS_MAX: assert property (
    low_cnt_ff <= RAS_MAX_CYC)
    else $error("row low pulse long");
  AST_CAS_MIN: assert property (
    $fell(column_strobe_n) && !row_strobe_n |-> !column_strobe_n [*2])
    else $error("column low pulse short");
  AST_RAS_CAS_HI: assert property (
    $fell(row_strobe_n) && column_strobe_n |=> !$rose(column_strobe_n) [*4])
    else $error("column released early");
  AST_OE_RAS: assert property (
    $fell(output_enable_n) |-> !row_strobe_n [*2])
    else $error("row hold after enable short");
  AST_WE_SETUP: assert property (
    $fell(column_strobe_n) && mem_data_oe |-> $past(write_strobe_n) == 1'b0 ##1 !write_strobe_n)
    else $error("write strobe setup or hold short");
  AST_WDATA: assert property (
    $fell(column_strobe_n) && mem_data_oe |=> $stable(mem_data_o) && mem_data_oe)
    else $error("write data hold short");
  AST_REF_SETUP: assert property (
    $fell(row_strobe_n) && !column_strobe_n |-> $past(column_strobe_n) == 1'b0 ##1 !column_strobe_n)
    else $error("refresh column setup or hold short");
  AST_REF_CAS_HI: assert property (
    $fell(column_strobe_n) && row_strobe_n |-> $past(column_strobe_n, 2) && $past(row_strobe_n))
    else $error("refresh column precharge short");
  AST_IDLE: assert property (
    !busy |-> row_strobe_n && column_strobe_n && write_strobe_n && output_enable_n && !mem_data_oe)
    else $error("strobe active while idle");
endmodule : ddsq_checker

bind ddsq_sequencer ddsq_checker #(.RAS_MAX_CYC(RAS_MAX_CYC)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .busy(busy), .row_strobe_n(row_strobe_n),
  .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
  .output_enable_n(output_enable_n), .mem_addr(mem_addr), .mem_data_o(mem_data_o),
  .mem_data_oe(mem_data_oe)
);

// file: ddsq_dram_model.sv
// Purpose: Behavioural page-mode DRAM on the display memory pins
// Assumes: An undriven data bus shows the inverse of the last word
// Notes: DLY_NS sets read access and hold delay
`timescale 1ns/1ns

module ddsq_dram_model #(
  parameter int DLY_NS = 10
) (
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire ddsq_pkg::ddsq_addr_t mem_addr,
  input wire ddsq_pkg::ddsq_data_t mem_data_o,
  input wire logic mem_data_oe,
  output ddsq_pkg::ddsq_data_t mem_data_i
);
  import ddsq_pkg::*;
  ddsq_data_t cells [bit [17:0]];
  ddsq_addr_t row_q = 9'h000;
  ddsq_data_t last_q = 16'h0000;
  bit [17:0] at_q = 18'h00000;
  // ----------------------------------------------------------------
  // Storage and read path
  // ----------------------------------------------------------------
  always @(negedge row_strobe_n) begin
    if (column_strobe_n) row_q = mem_addr;
  end
  always @(negedge column_strobe_n) begin
    if (!row_strobe_n) begin
      at_q = {row_q, mem_addr};
      if (!write_strobe_n && mem_data_oe) cells[at_q] = mem_data_o;
    end
  end
  always @(row_strobe_n, column_strobe_n, output_enable_n, at_q) begin
    if (!row_strobe_n && !column_strobe_n && !output_enable_n && cells.exists(at_q)) begin
      last_q = cells[at_q];
      mem_data_i <= #DLY_NS last_q;
    end else begin
      mem_data_i <= #DLY_NS ~last_q;
    end
  end
endmodule : ddsq_dram_model

// file: display_dram_sequencer_bench.sv
// Purpose: Self-checking bench for the display DRAM sequencer
// Assumes: DRAM model on the memory pins, SEQ_DIV of 1
// Notes: Read words are checked against a queue of expected words
`timescale 1ns/1ns

module display_dram_sequencer_bench;
  import ddsq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  ddsq_addr_t cmd_row = 9'h000;
  ddsq_addr_t cmd_col = 9'h000;
  ddsq_addr_t r;
  ddsq_data_t cmd_wdata = 16'h0000;
  logic cmd_write = 1'b0;
  logic cmd_valid = 1'b0;
  logic ref_req = 1'b0;
  logic ref_four = 1'b0;
  logic cmd_ready, rd_valid, ref_ack, busy, mem_data_oe, row_d;
  logic row_strobe_n, column_strobe_n, write_strobe_n, output_enable_n;
  logic saw_full = 1'b0;
  ddsq_data_t rd_data, mem_data_o, mem_data_i;
  ddsq_addr_t mem_addr;
  ddsq_data_t shadow [bit [17:0]];
  ddsq_data_t expq [$];
  int seed = 84;
  int n_errors = 0;
  int cmp_count = 0;
  int pulses = 0;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  always #4 clk_sys = ~clk_sys;
  ddsq_sequencer #(.SEQ_DIV(8'h01), .RAS_MAX_CYC(64)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .cmd_row(cmd_row), .cmd_col(cmd_col),
    .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid), .ref_req(ref_req),
    .ref_four(ref_four), .ref_ack(ref_ack), .busy(busy), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .mem_addr(mem_addr), .mem_data_o(mem_data_o),
    .mem_data_oe(mem_data_oe), .mem_data_i(mem_data_i));
  ddsq_dram_model u_mem (
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .mem_addr(mem_addr), .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe),
    .mem_data_i(mem_data_i));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic send(input ddsq_addr_t row, input ddsq_addr_t col, input logic wr);
    cmd_row = row;
    cmd_col = col;
    cmd_write = wr;
    cmd_wdata = 16'($random(seed));
    cmd_valid = 1'b1;
    if (wr) shadow[{row, col}] = cmd_wdata;
    else expq.push_back(shadow[{row, col}]);
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask : send

  task automatic drain();
    int quiet;
    cmd_valid = 1'b0;
    quiet = 0;
    while (quiet < 4) begin
      @(negedge clk_sys);
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
  endtask : drain

  task automatic refresh(input logic four);
    ref_four = four;
    ref_req = 1'b1;
    pulses = 0;
    while (ref_ack !== 1'b1) @(negedge clk_sys);
    ref_req = 1'b0;
    drain();
    check("pulses", 32'(pulses), 32'(3 + four));
  endtask : refresh

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Result watcher: row pulses under a low column strobe, refusals, read words
  always @(negedge clk_sys) begin
    if (row_d === 1'b1 && row_strobe_n === 1'b0 && column_strobe_n === 1'b0) pulses++;
    row_d = row_strobe_n;
    if (cmd_ready === 1'b0) saw_full = 1'b1;
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) check("spare_read", 32'h1, 32'h0);
      else check("rd_data", 32'(rd_data), 32'(expq.pop_front()));
    end
  end

  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    check("idle", 32'({row_strobe_n, column_strobe_n, write_strobe_n,
      output_enable_n, busy, cmd_ready}), 32'h3D);
    for (int i = 0; i < 6; i++) send(9'h005, 9'(i), 1'b1);
    for (int i = 0; i < 6; i++) send(9'h005, 9'(i), 1'b0);
    drain();
    check("refused", 32'(saw_full), 32'h1);
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 9'h1FF : 9'($random(seed));
      send(r, ~r, 1'b1);
      send(r, ~r, 1'b0);
    end
    drain();
    refresh(1'b0);
    refresh(1'b1);
    send(9'h005, 9'h000, 1'b0);
    drain();
    send(9'h0AA, 9'h055, 1'b1);
    cmd_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    check("idle2", 32'({row_strobe_n, column_strobe_n, busy}), 32'h6);
    check("left", 32'(expq.size()), 32'h0);
    give_verdict();
  end
endmodule : display_dram_sequencer_bench
